// ==== rtl/pae_err_regs.sv ====
// Error reporting register bank: masks, severity, status and reporting
`timescale 1ns/1ns
`default_nettype none
module pae_err_regs (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hot_rst,
  input wire logic [pae_pkg::ADDR_W-1:0] addr,
  input wire logic [pae_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [pae_pkg::DATA_W-1:0] rdata,
  input wire logic [pae_pkg::UNC_W-1:0] unc_evt,
  input wire logic [pae_pkg::COR_W-1:0] cor_evt,
  output logic hdr_log_req,
  output logic [pae_pkg::UNC_W-1:0] hdr_log_src,
  output logic msg_fatal,
  output logic msg_nonfatal,
  output logic msg_cor,
  output logic irq
);

  // Address match used by every write select
  function automatic logic hit(
    input logic [pae_pkg::ADDR_W-1:0] a,
    input logic [pae_pkg::ADDR_W-1:0] off
  );
    hit = (a == off);
  endfunction

  // Zero-extend a narrow register into a bus word
  function automatic logic [pae_pkg::DATA_W-1:0] unc_word(
    input logic [pae_pkg::UNC_W-1:0] v
  );
    unc_word = {{(pae_pkg::DATA_W - pae_pkg::UNC_W){1'b0}}, v};
  endfunction

  function automatic logic [pae_pkg::DATA_W-1:0] cor_word(
    input logic [pae_pkg::COR_W-1:0] v
  );
    cor_word = {{(pae_pkg::DATA_W - pae_pkg::COR_W){1'b0}}, v};
  endfunction

  logic [pae_pkg::UNC_W-1:0] unc_sts;
  logic [pae_pkg::UNC_W-1:0] unc_msk;
  logic [pae_pkg::UNC_W-1:0] unc_sev;
  logic [pae_pkg::COR_W-1:0] cor_sts;
  logic [pae_pkg::COR_W-1:0] cor_msk;
  logic [pae_pkg::IRQ_W-1:0] irq_sts;
  logic [pae_pkg::IRQ_W-1:0] irq_ena;
  logic [pae_pkg::IRQ_W-1:0] irq_set;
  logic [pae_pkg::UNC_W-1:0] unc_rep;
  logic [pae_pkg::COR_W-1:0] cor_rep;
  logic [pae_pkg::DATA_W-1:0] rdata_reg;
  logic [pae_pkg::DATA_W-1:0] rdata_next;
  logic hdr_log_reg;
  logic [pae_pkg::UNC_W-1:0] hdr_src_reg;
  logic msg_fatal_reg;
  logic msg_nonfatal_reg;
  logic msg_cor_reg;
  logic irq_reg;
  logic rep_fatal;
  logic rep_nonfatal;
  logic rep_cor;

  pae_wr_if #(.W(pae_pkg::UNC_W)) unc_sts_wr ();
  pae_wr_if #(.W(pae_pkg::UNC_W)) unc_msk_wr ();
  pae_wr_if #(.W(pae_pkg::UNC_W)) unc_sev_wr ();
  pae_wr_if #(.W(pae_pkg::COR_W)) cor_sts_wr ();
  pae_wr_if #(.W(pae_pkg::COR_W)) cor_msk_wr ();
  pae_wr_if #(.W(pae_pkg::IRQ_W)) irq_sts_wr ();
  pae_wr_if #(.W(pae_pkg::IRQ_W)) irq_ena_wr ();

  // Write selects; reserved bit writes are dropped inside the banks
  assign unc_sts_wr.we = wr && hit(addr, pae_pkg::UNC_STS_OFF);
  assign unc_msk_wr.we = wr && hit(addr, pae_pkg::UNC_MSK_OFF);
  assign unc_sev_wr.we = wr && hit(addr, pae_pkg::UNC_SEV_OFF);
  assign cor_sts_wr.we = wr && hit(addr, pae_pkg::COR_STS_OFF);
  assign cor_msk_wr.we = wr && hit(addr, pae_pkg::COR_MSK_OFF);
  assign irq_sts_wr.we = wr && hit(addr, pae_pkg::IRQ_STS_OFF);
  assign irq_ena_wr.we = wr && hit(addr, pae_pkg::IRQ_ENA_OFF);

  // Narrow write data slices
  assign unc_sts_wr.wdata = wdata[pae_pkg::UNC_W-1:0];
  assign unc_msk_wr.wdata = wdata[pae_pkg::UNC_W-1:0];
  assign unc_sev_wr.wdata = wdata[pae_pkg::UNC_W-1:0];
  assign cor_sts_wr.wdata = wdata[pae_pkg::COR_W-1:0];
  assign cor_msk_wr.wdata = wdata[pae_pkg::COR_W-1:0];
  assign irq_sts_wr.wdata = wdata[pae_pkg::IRQ_W-1:0];
  assign irq_ena_wr.wdata = wdata[pae_pkg::IRQ_W-1:0];

  // Uncorrectable status, one flag per event at the mask positions
  pae_w1c_bank #(
    .W(pae_pkg::UNC_W),
    .VALID(pae_pkg::UNC_VALID),
    .RSTV(pae_pkg::UNC_STS_RST)
  ) u_unc_sts (
    .clk(clk),
    .rstn(rstn),
    .clr(1'b0),
    .set(unc_evt),
    .wr(unc_sts_wr),
    .q(unc_sts)
  );

  // Uncorrectable mask, sticky, resets to all clear
  pae_rw_bank #(
    .W(pae_pkg::UNC_W),
    .VALID(pae_pkg::UNC_VALID),
    .RSTV(pae_pkg::UNC_MSK_RST)
  ) u_unc_msk (
    .clk(clk),
    .rstn(rstn),
    .wr(unc_msk_wr),
    .q(unc_msk)
  );

  // Severity, sticky, mixed reset pattern
  pae_rw_bank #(
    .W(pae_pkg::UNC_W),
    .VALID(pae_pkg::UNC_VALID),
    .RSTV(pae_pkg::UNC_SEV_RST)
  ) u_unc_sev (
    .clk(clk),
    .rstn(rstn),
    .wr(unc_sev_wr),
    .q(unc_sev)
  );

  // Correctable status: receiver error, bad TLP, bad DLLP, rollover, timeout
  pae_w1c_bank #(
    .W(pae_pkg::COR_W),
    .VALID(pae_pkg::COR_VALID),
    .RSTV(pae_pkg::COR_STS_RST)
  ) u_cor_sts (
    .clk(clk),
    .rstn(rstn),
    .clr(1'b0),
    .set(cor_evt),
    .wr(cor_sts_wr),
    .q(cor_sts)
  );

  // Correctable mask at the same positions
  pae_rw_bank #(
    .W(pae_pkg::COR_W),
    .VALID(pae_pkg::COR_VALID),
    .RSTV(pae_pkg::COR_MSK_RST)
  ) u_cor_msk (
    .clk(clk),
    .rstn(rstn),
    .wr(cor_msk_wr),
    .q(cor_msk)
  );

  // Interrupt causes; not sticky, so a hot reset wipes all but a cause set in that same cycle
  pae_w1c_bank #(
    .W(pae_pkg::IRQ_W),
    .VALID(pae_pkg::IRQ_VALID),
    .RSTV(pae_pkg::IRQ_RST)
  ) u_irq_sts (
    .clk(clk),
    .rstn(rstn),
    .clr(hot_rst),
    .set(irq_set),
    .wr(irq_sts_wr),
    .q(irq_sts)
  );

  // Interrupt enables, also cleared by hot reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_ena <= pae_pkg::IRQ_RST;
    end else if (hot_rst) begin
      irq_ena <= pae_pkg::IRQ_RST;
    end else if (irq_ena_wr.we) begin
      irq_ena <= irq_ena_wr.wdata & pae_pkg::IRQ_VALID;
    end
  end

  // Reportable events: a set mask bit hides both logging and messaging
  // Reserved event lines are ignored so stray inputs never report
  assign unc_rep = unc_evt & ~unc_msk & pae_pkg::UNC_VALID;
  assign cor_rep = cor_evt & ~cor_msk & pae_pkg::COR_VALID;

  // Severity splits uncorrectable reports into fatal and non-fatal
  assign rep_fatal = |(unc_rep & unc_sev);
  assign rep_nonfatal = |(unc_rep & ~unc_sev);
  assign rep_cor = |cor_rep;

  // Interrupt cause mapping
  always_comb begin
    irq_set = '0;
    irq_set[pae_pkg::IRQ_FATAL_BIT] = rep_fatal;
    irq_set[pae_pkg::IRQ_NONFATAL_BIT] = rep_nonfatal;
    irq_set[pae_pkg::IRQ_COR_BIT] = rep_cor;
  end

  // Header log request for unmasked uncorrectable events only
  // Masked events still set status, so software can poll them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hdr_log_reg <= 1'b0;
      hdr_src_reg <= '0;
    end else if (hot_rst) begin
      hdr_log_reg <= 1'b0;
      hdr_src_reg <= '0;
    end else begin
      hdr_log_reg <= |unc_rep;
      hdr_src_reg <= unc_rep;
    end
  end

  // Error message pulses toward the root complex
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      msg_fatal_reg <= 1'b0;
      msg_nonfatal_reg <= 1'b0;
      msg_cor_reg <= 1'b0;
    end else if (hot_rst) begin
      msg_fatal_reg <= 1'b0;
      msg_nonfatal_reg <= 1'b0;
      msg_cor_reg <= 1'b0;
    end else begin
      msg_fatal_reg <= rep_fatal;
      msg_nonfatal_reg <= rep_nonfatal;
      msg_cor_reg <= rep_cor;
    end
  end

  // Level interrupt, one cycle behind the cause flags
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_reg <= 1'b0;
    end else if (hot_rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_sts & irq_ena);
    end
  end

  // Read mux; reserved bits come back zero from the banks
  always_comb begin
    rdata_next = '0;
    case (addr)
      pae_pkg::UNC_STS_OFF: rdata_next = unc_word(unc_sts);
      pae_pkg::UNC_MSK_OFF: rdata_next = unc_word(unc_msk);
      pae_pkg::UNC_SEV_OFF: rdata_next = unc_word(unc_sev);
      pae_pkg::COR_STS_OFF: rdata_next = cor_word(cor_sts);
      pae_pkg::COR_MSK_OFF: rdata_next = cor_word(cor_msk);
      pae_pkg::IRQ_STS_OFF: begin
        rdata_next = {{(pae_pkg::DATA_W - pae_pkg::IRQ_W){1'b0}}, irq_sts};
      end
      pae_pkg::IRQ_ENA_OFF: begin
        rdata_next = {{(pae_pkg::DATA_W - pae_pkg::IRQ_W){1'b0}}, irq_ena};
      end
      default: rdata_next = '0;
    endcase
  end

  // Read data valid only the cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= '0;
    end else if (rd) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= '0;
    end
  end

  // Every output comes straight from its flop
  assign rdata = rdata_reg;
  assign hdr_log_req = hdr_log_reg;
  assign hdr_log_src = hdr_src_reg;
  assign msg_fatal = msg_fatal_reg;
  assign msg_nonfatal = msg_nonfatal_reg;
  assign msg_cor = msg_cor_reg;
  assign irq = irq_reg;

endmodule
`default_nettype wire

// ==== rtl/pae_pkg.sv ====
// Constants and register map of the error reporting register bank
//
// Functional notes
// - Mask bit 0 hides training error reports
// - Mask bit 4 hides data link protocol errors
// - Mask bit 12 hides poisoned TLP reports
// - Mask bits 13-17 hide their own events
// - Mask bits 18-20 hide; mask resets zero
// - Severity bit one fatal, zero non-fatal
// - Severity reset fatal for five error types
// - Receiver error sets correctable status bit 0
// - Bad TLP sets bit 6, bad DLLP 7
// - Replay counter rollover sets status bit 8
// - Replay timer timeout sets status bit 12
// - Uncorrectable status flags share mask bit positions
// - Correctable mask hides correctable event reports
package pae_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int UNC_W = 21;
  localparam int COR_W = 13;
  localparam int IRQ_W = 3;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] UNC_STS_OFF = 12'h104;
  localparam logic [ADDR_W-1:0] UNC_MSK_OFF = 12'h108;
  localparam logic [ADDR_W-1:0] UNC_SEV_OFF = 12'h10c;
  localparam logic [ADDR_W-1:0] COR_STS_OFF = 12'h110;
  localparam logic [ADDR_W-1:0] COR_MSK_OFF = 12'h114;
  localparam logic [ADDR_W-1:0] IRQ_STS_OFF = 12'h130;
  localparam logic [ADDR_W-1:0] IRQ_ENA_OFF = 12'h134;

  // Implemented bit positions; all others are reserved
  localparam logic [UNC_W-1:0] UNC_VALID = 21'h1ff011;
  localparam logic [COR_W-1:0] COR_VALID = 13'h11c1;
  localparam logic [IRQ_W-1:0] IRQ_VALID = 3'h7;

  // Reset values
  localparam logic [UNC_W-1:0] UNC_MSK_RST = 21'h000000;
  localparam logic [UNC_W-1:0] UNC_SEV_RST = 21'h062011;
  localparam logic [UNC_W-1:0] UNC_STS_RST = 21'h000000;
  localparam logic [COR_W-1:0] COR_STS_RST = 13'h0000;
  localparam logic [COR_W-1:0] COR_MSK_RST = 13'h0000;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  // Interrupt cause positions
  localparam int IRQ_FATAL_BIT = 0;
  localparam int IRQ_NONFATAL_BIT = 1;
  localparam int IRQ_COR_BIT = 2;

endpackage

// ==== rtl/pae_wr_if.sv ====
// Write carrier between the register decoder and a storage bank
`timescale 1ns/1ns
`default_nettype none
interface pae_wr_if #(
  parameter int W = 32
);
  logic we;
  logic [W-1:0] wdata;
  modport drv (output we, output wdata);
  modport snk (input we, input wdata);
endinterface
`default_nettype wire

// ==== rtl/pae_rw_bank.sv ====
// Sticky read-write register bank with per-bit reset values
`timescale 1ns/1ns
`default_nettype none
module pae_rw_bank #(
  parameter int W = 21,
  parameter logic [W-1:0] VALID = '1,
  parameter logic [W-1:0] RSTV = '0
) (
  input wire logic clk,
  input wire logic rstn,
  pae_wr_if.snk wr,
  output logic [W-1:0] q
);

  // Only power-on reset touches these bits
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      if (VALID[i]) begin : g_impl
        always_ff @(posedge clk or negedge rstn) begin
          if (!rstn) begin
            q[i] <= RSTV[i];
          end else if (wr.we) begin
            q[i] <= wr.wdata[i];
          end
        end
      end else begin : g_rsvd
        assign q[i] = 1'b0;
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ==== rtl/pae_w1c_bank.sv ====
// Sticky write-one-to-clear status bank, a set beats a clear
`timescale 1ns/1ns
`default_nettype none
module pae_w1c_bank #(
  parameter int W = 13,
  parameter logic [W-1:0] VALID = '1,
  parameter logic [W-1:0] RSTV = '0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clr,
  input wire logic [W-1:0] set,
  pae_wr_if.snk wr,
  output logic [W-1:0] q
);

  // Clr is a synchronous wipe for non-sticky users; sticky users tie it low
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      if (VALID[i]) begin : g_impl
        always_ff @(posedge clk or negedge rstn) begin
          if (!rstn) begin
            q[i] <= RSTV[i];
          end else if (set[i]) begin
            q[i] <= 1'b1;
          end else if (clr || (wr.we && wr.wdata[i])) begin
            q[i] <= 1'b0;
          end
        end
      end else begin : g_rsvd
        assign q[i] = 1'b0;
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ==== tb/pae_err_regs_props.sv ====
// Assertion checker for the error reporting register bank
`timescale 1ns/1ns
`default_nettype none
module pae_err_regs_props (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hot_rst,
  input wire logic [pae_pkg::ADDR_W-1:0] addr,
  input wire logic [pae_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [pae_pkg::DATA_W-1:0] rdata,
  input wire logic [pae_pkg::UNC_W-1:0] unc_evt,
  input wire logic [pae_pkg::COR_W-1:0] cor_evt,
  input wire logic hdr_log_req,
  input wire logic [pae_pkg::UNC_W-1:0] hdr_log_src,
  input wire logic msg_fatal,
  input wire logic msg_nonfatal,
  input wire logic msg_cor,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Mask bits 31:21 read zero; header, fatal and correctable reports trace back to an event one cycle earlier
  chk_rd_reserved: assert property (
    rd && addr == pae_pkg::UNC_MSK_OFF |=> rdata[31:21] == 11'h000)
    else $error("reserved mask bits read nonzero");
  chk_hdr_cause: assert property (
    hdr_log_req |-> $past(|(unc_evt & pae_pkg::UNC_VALID)))
    else $error("header log without event");
  chk_hdr_src_sub: assert property (
    (hdr_log_src & ~$past(unc_evt)) == '0)
    else $error("header source not an event");
  chk_hdr_pair: assert property (
    hdr_log_req == (hdr_log_src != '0))
    else $error("header request and source disagree");
  chk_fatal_cause: assert property (
    msg_fatal |-> $past(|(unc_evt & pae_pkg::UNC_VALID)))
    else $error("fatal message without event");
  chk_cor_cause: assert property (
    msg_cor |-> $past(|(cor_evt & pae_pkg::COR_VALID)))
    else $error("correctable message without event");
  chk_msg_hdr: assert property (
    (msg_fatal || msg_nonfatal) |-> hdr_log_req)
    else $error("message without header log");
  chk_hot_quiet: assert property (
    hot_rst |=> !msg_fatal && !msg_nonfatal && !hdr_log_req)
    else $error("report after hot reset");
  cover property (msg_fatal);
  cover property (msg_cor);
  cover property ($rose(irq));
endmodule
bind pae_err_regs pae_err_regs_props chk_u (.clk, .rstn, .hot_rst, .addr, .wdata, .wr, .rd,
  .rdata, .unc_evt, .cor_evt, .hdr_log_req, .hdr_log_src, .msg_fatal, .msg_nonfatal,
  .msg_cor, .irq);
`default_nettype wire

// ==== tb/pae_rc_model.sv ====
// Root complex model that counts error messages
`timescale 1ns/1ns
`default_nettype none
module pae_rc_model (
  input wire logic clk,
  input wire logic msg_fatal,
  input wire logic msg_nonfatal,
  input wire logic msg_cor,
  output var int n_msg
);
  // Each pulse is one message on the link
  initial n_msg = 0;
  always @(posedge clk) begin
    n_msg <= n_msg + int'(msg_fatal) + int'(msg_nonfatal) + int'(msg_cor);
  end
endmodule
`default_nettype wire

// ==== tb/pae_err_regs_test.sv ====
// Self-checking testbench of the error reporting register bank
`timescale 1ns/1ns
`default_nettype none
module pae_err_regs_test;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic hot_rst = 1'b0;
  logic [11:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [20:0] unc_evt = '0;
  logic [12:0] cor_evt = '0;
  logic hdr_log_req, msg_fatal, msg_nonfatal, msg_cor, irq;
  logic [20:0] hdr_log_src;
  logic [31:0] q;
  int err_count = 0;
  int total_checks = 0;
  int exp_msg = 0;
  int cyc = 0;
  int n_msg;
  // Free running clock
  always #10 clk = ~clk;
  pae_err_regs dut_u (.clk, .rstn, .hot_rst, .addr, .wdata, .wr, .rd, .rdata, .unc_evt,
    .cor_evt, .hdr_log_req, .hdr_log_src, .msg_fatal, .msg_nonfatal, .msg_cor, .irq);
  pae_rc_model rc_u (.clk, .msg_fatal, .msg_nonfatal, .msg_cor, .n_msg);
  task automatic stop_test;
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Hang guard, far above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      stop_test;
    end
  end
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic bw(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic br(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic ev(input logic [20:0] u, input logic [12:0] c);
    @(posedge clk);
    unc_evt <= u; cor_evt <= c;
    @(posedge clk);
    unc_evt <= '0; cor_evt <= '0;
    #1;
  endtask
  task automatic t_defaults;
    br(pae_pkg::UNC_SEV_OFF, q); chk(32'h00062011, q);
    br(pae_pkg::UNC_MSK_OFF, q); chk(32'h00000000, q);
    br(pae_pkg::COR_STS_OFF, q); chk(32'h00000000, q);
    br(12'h200, q); chk(32'h00000000, q);
    bw(pae_pkg::UNC_MSK_OFF, 32'hffffffff);
    br(pae_pkg::UNC_MSK_OFF, q); chk(32'h001ff011, q);
    bw(pae_pkg::UNC_MSK_OFF, 32'h00000000);
  endtask
  // Masked then unmasked, with both severities, for every error type
  task automatic t_unc;
    logic [20:0] b;
    for (int i = 0; i < 21; i++) begin
      if (pae_pkg::UNC_VALID[i]) begin
        b = 21'h000001 << i;
        bw(pae_pkg::UNC_MSK_OFF, {11'h000, b});
        ev(b, '0);
        chk(0, hdr_log_req | msg_fatal | msg_nonfatal);
        br(pae_pkg::UNC_STS_OFF, q); chk({11'h000, b}, q);
        bw(pae_pkg::UNC_MSK_OFF, 32'h00000000);
        ev(b, '0);
        chk(1, hdr_log_req);
        chk(b, hdr_log_src);
        chk(pae_pkg::UNC_SEV_RST[i], msg_fatal);
        chk(!pae_pkg::UNC_SEV_RST[i], msg_nonfatal);
        bw(pae_pkg::UNC_SEV_OFF, {11'h000, ~pae_pkg::UNC_SEV_RST});
        ev(b, '0);
        chk(!pae_pkg::UNC_SEV_RST[i], msg_fatal);
        bw(pae_pkg::UNC_SEV_OFF, {11'h000, pae_pkg::UNC_SEV_RST});
        bw(pae_pkg::UNC_STS_OFF, {11'h000, b});
        br(pae_pkg::UNC_STS_OFF, q); chk(0, q);
        exp_msg += 2;
      end
    end
  endtask
  task automatic t_cor;
    logic [12:0] b;
    for (int i = 0; i < 13; i++) begin
      if (pae_pkg::COR_VALID[i]) begin
        b = 13'h0001 << i;
        ev('0, b);
        chk(1, msg_cor);
        br(pae_pkg::COR_STS_OFF, q); chk({19'h0, b}, q);
        bw(pae_pkg::COR_STS_OFF, {19'h0, b});
        br(pae_pkg::COR_STS_OFF, q); chk(0, q);
        bw(pae_pkg::COR_MSK_OFF, {19'h0, b});
        ev('0, b);
        chk(0, msg_cor);
        bw(pae_pkg::COR_STS_OFF, {19'h0, b});
        bw(pae_pkg::COR_MSK_OFF, 32'h00000000);
        exp_msg++;
      end
    end
  endtask
  // Interrupt raised while enabled, cleared, and held off when disabled
  task automatic t_irq;
    // Earlier scenarios leave cause flags set; start from a clean state
    bw(pae_pkg::IRQ_STS_OFF, 32'h00000007);
    bw(pae_pkg::IRQ_ENA_OFF, 32'h00000004);
    @(posedge clk); #1 chk(0, irq);
    ev('0, 13'h0001);
    @(posedge clk); #1 chk(1, irq);
    bw(pae_pkg::IRQ_STS_OFF, 32'h00000004);
    @(posedge clk); #1 chk(0, irq);
    bw(pae_pkg::IRQ_ENA_OFF, 32'h00000000);
    ev('0, 13'h0001);
    @(posedge clk); #1 chk(0, irq);
    bw(pae_pkg::IRQ_STS_OFF, 32'h00000007);
    bw(pae_pkg::COR_STS_OFF, 32'h00000001);
    exp_msg += 2;
  endtask
  // Sticky bits survive hot reset but not power-on reset
  task automatic t_hot;
    bw(pae_pkg::UNC_MSK_OFF, 32'h00000010);
    bw(pae_pkg::IRQ_ENA_OFF, 32'h00000007);
    ev('0, 13'h0040);
    exp_msg++;
    @(posedge clk) hot_rst <= 1'b1;
    @(posedge clk) hot_rst <= 1'b0;
    br(pae_pkg::UNC_MSK_OFF, q); chk(32'h00000010, q);
    br(pae_pkg::COR_STS_OFF, q); chk(32'h00000040, q);
    br(pae_pkg::IRQ_ENA_OFF, q); chk(0, q);
    br(pae_pkg::IRQ_STS_OFF, q); chk(0, q);
    chk(0, irq);
    @(posedge clk) rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    br(pae_pkg::UNC_MSK_OFF, q); chk(0, q);
    br(pae_pkg::COR_STS_OFF, q); chk(0, q);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_defaults;
    t_unc;
    t_cor;
    t_irq;
    t_hot;
    chk(exp_msg, n_msg);
    stop_test;
  end
endmodule
`default_nettype wire
